// *** tae_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module tae_checker #(
    parameter int TIMEOUT_CYCLES = 200,
    parameter int SAMPLE_CYCLES  = 100
) (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        clk_en,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_rdata,
    input wire logic        sample_req,
    input wire logic        temp_sample_valid,
    input wire logic        scl_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_n,
    input wire logic        alarm_oe_n
);
    int lowc_q;  // Raw clock-low run, saturating
    int smp_q;   // Cycles since the last sample request
    // Raw pin counts run ahead of the synchroniser, so bounds carry slack
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lowc_q <= 0;
            smp_q  <= 0;
        end else if (clk_en) begin
            lowc_q <= scl_i ? 0 : (lowc_q < 99999 ? lowc_q + 1 : lowc_q);
            smp_q  <= sample_req ? 0 : smp_q + 1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_rdata_blank:
        assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data outside slot");
    a_limit_top_zero:
        assert property ($past(reg_rd) && $past(reg_addr) >= 4'h2 && $past(reg_addr) <= 4'h5
            |-> reg_rdata[15:13] == 3'b000) else $error("limit top bits set");
    a_sda_open_drain:
        assert property (sda_o == 1'b0) else $error("data pin driven high");
    a_timeout_release:
        assert property (lowc_q > TIMEOUT_CYCLES + 8 |-> sda_oe_n) else $error("data held past timeout");
    a_sample_pulse:
        assert property (sample_req |=> !sample_req [*8]) else $error("sample request too long");
    a_sample_due:
        assert property (smp_q <= SAMPLE_CYCLES + 1) else $error("sample request late");
    a_alarm_cause:
        assert property ($changed(alarm_oe_n) |-> $past(temp_sample_valid) || $past(reg_wr))
            else $error("alarm moved without cause");
    a_read_no_effect:
        assert property (reg_rd && !temp_sample_valid |=> $stable(alarm_oe_n)) else $error("read moved alarm");
    c_alarm_on: cover property ($fell(alarm_oe_n));
    c_ack: cover property ($fell(sda_oe_n));
    c_timeout: cover property (lowc_q > TIMEOUT_CYCLES + 8);
endmodule
bind tae_top tae_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .SAMPLE_CYCLES(SAMPLE_CYCLES)) tae_checker_i (.*);
`default_nettype wire

// *** tae_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Bus host: address byte, acknowledge, then a forced clock-low timeout
module tae_host #(
    parameter int HOLD_NS = 7500
) (
    input wire logic       go,
    input wire logic [6:0] addr,
    input wire logic       sda_in,
    output logic           scl,
    output logic           sda,
    output logic           acked,
    output logic           busy
);
    logic [7:0] b;  // Address byte, write direction
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        acked = 1'b0;
        busy = 1'b0;
    end
    // Clock stands still between frames; data changes while clock low except at start and stop
    always @(posedge go) begin
        busy = 1'b1;
        b = {addr, 1'b0};
        sda = 1'b0;
        #100 scl = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #50 sda = b[i];
            #50 scl = 1'b1;
            #100 scl = 1'b0;
        end
        #50 sda = 1'b1;
        #50 scl = 1'b1;
        // Late sample: the device sees edges through a synchroniser
        #90 acked = !sda_in;
        #10 scl = 1'b0;
        #50 sda = 1'b0;
        #HOLD_NS scl = 1'b1;
        #100 sda = 1'b1;
        #100 busy = 1'b0;
    end
endmodule
`default_nettype wire

// *** tae_pkg.sv ***
// Shared constants and carrier types for the temperature alarm block
package tae_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] REG_CAPS   = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_UPPER  = 4'h2;
    localparam logic [3:0] REG_LOWER  = 4'h3;
    localparam logic [3:0] REG_CRIT   = 4'h4;
    localparam logic [3:0] REG_TEMP   = 4'h5;

    // Configuration register field positions
    localparam int CFG_INT_MODE  = 0;   // 1 latched interrupt, 0 comparator
    localparam int CFG_POL_HIGH  = 1;   // 1 active high, 0 active low
    localparam int CFG_CRIT_ONLY = 2;   // Critical-only mode
    localparam int CFG_WIN_EN    = 3;   // Upper/lower window alarms enabled
    localparam int CFG_STATUS    = 4;   // Read only: alarm asserted
    localparam int CFG_CLEAR     = 5;   // Write 1 clears latched interrupt
    localparam int CFG_SHUTDOWN  = 8;   // Shutdown, samples ignored
    localparam int CFG_HYST_LO   = 9;   // Hysteresis select, bits 10:9

    // Capability register field positions
    localparam int CAP_TMO_SEL   = 6;
    localparam int CAP_SD_REL    = 7;

    // Reset values
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    localparam logic [12:0] LIMIT_RST  = 13'h0000;

    // Hysteresis amounts in 1/16 degree steps: 0, 1.5, 3, 6 degrees
    localparam logic [13:0] HYST_0 = 14'h0000;
    localparam logic [13:0] HYST_1 = 14'h0018;
    localparam logic [13:0] HYST_2 = 14'h0030;
    localparam logic [13:0] HYST_3 = 14'h0060;

    // Slave address upper nibble
    localparam logic [3:0] SLAVE_HI = 4'h3;

    // Timing, in the units printed, and derived cycle counts at 40 MHz
    localparam int CLK_KHZ        = 40000;
    localparam int TIMEOUT_MIN_MS = 25;
    localparam int TIMEOUT_MAX_MS = 35;
    localparam int SAMPLE_MS      = 100;
    localparam int TIMEOUT_CYC    = TIMEOUT_MIN_MS * CLK_KHZ;
    localparam int SAMPLE_CYC     = SAMPLE_MS * CLK_KHZ;

    // Serial slave states
    typedef enum logic [2:0] {
        SS_IDLE   = 3'b000,
        SS_ADDR   = 3'b001,
        SS_ACK_A  = 3'b010,
        SS_RD     = 3'b011,
        SS_RD_ACK = 3'b100,
        SS_WR     = 3'b101,
        SS_WR_ACK = 3'b110
    } tae_slv_e;

    // Alarm configuration as one carrier
    typedef struct packed {
        logic       int_mode;
        logic       pol_high;
        logic       crit_only;
        logic       win_en;
        logic       shutdown;
        logic [1:0] hyst_sel;
    } tae_cfg_s;

    // Alarm limits as one carrier
    typedef struct packed {
        logic [12:0] upper;
        logic [12:0] lower;
        logic [12:0] crit;
    } tae_lim_s;

endpackage

// *** tae_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; output follows once stages two and three agree
module tae_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    // All state of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;    // Metastable stage, read only by s2
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;  // Agreed level
    } tae_sync_s;

    tae_sync_s st_q, st_d;

    // Shift and filter
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            // A single-cycle disagreement is treated as a glitch
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.filt[i] = st_q.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign pin_out = st_q.filt;
endmodule
`default_nettype wire

// *** tae_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
// Interval counter: pulses after CYCLES enabled cycles without a clear
module tae_tick #(
    parameter int CYCLES = 16
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic clr,
    output logic      done
);
    // All state of the counter
    typedef struct packed {
        logic [31:0] cnt;
        logic        done;
    } tae_tick_s;

    tae_tick_s st_q, st_d;

    // Count, wrap on reaching the limit
    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        if (clr) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == 32'(CYCLES - 1)) begin
            st_d.cnt  = '0;
            st_d.done = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 32'h0000_0001;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign done = st_q.done;
endmodule
`default_nettype wire

// *** tae_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tae_top #(
    parameter int          TIMEOUT_CYCLES = tae_pkg::TIMEOUT_CYC,  // Clock-low timeout
    parameter int          SAMPLE_CYCLES  = tae_pkg::SAMPLE_CYC,   // Sample request period
    parameter logic        CAP_TMO        = 1'b1,                  // Timeout range capability
    parameter logic        CAP_SD_RELEASE = 1'b0,                  // Shutdown release capability
    parameter logic [15:0] CAP_OTHER      = 16'h000F               // Remaining capability bits
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             sample_req,
    input  wire logic [12:0] temp_sample,
    input  wire logic        temp_sample_valid,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    input  wire logic        addr_select_bit0,
    input  wire logic        addr_select_bit1,
    input  wire logic        addr_select_bit2,
    output logic             alarm_o,
    output logic             alarm_oe_n
);
    // Complete state of the block
    typedef struct packed {
        tae_pkg::tae_cfg_s cfg;        // Alarm configuration
        tae_pkg::tae_lim_s lim;        // Limits
        logic [12:0]       temp;       // Latched temperature
        logic [15:0]       rdata;      // Read answer
        logic              above_up;   // Above upper limit, with hysteresis
        logic              below_lo;   // Below lower limit, with hysteresis
        logic              above_crit; // Above critical limit, with hysteresis
        logic              int_lat;    // Latched window interrupt
        logic              sd_rel;     // Released by shutdown entry
        logic              scl_d;      // Previous filtered clock
        logic              sda_d;      // Previous filtered data
        tae_pkg::tae_slv_e slv;        // Serial slave state
        logic [3:0]        bcnt;       // Bit count within byte
        logic [7:0]        sh;         // Receive shifter
        logic [7:0]        tx;         // Transmit shifter
        logic [15:0]       snap;       // Temperature word frozen for one read
        logic              rw;         // Direction of current transfer
        logic              byte_lo;    // Next read byte is the low one
        logic              m_ack;      // Master acknowledged last byte
        logic              sda_low;    // Pull data line low
    } tae_st_s;

    tae_st_s st_q, st_d;

    logic [4:0] pins_f;       // Filtered pins: select2..0, sda, scl
    logic       scl_f;
    logic       sda_f;
    logic [2:0] sel_f;
    logic       tmo_hit;      // Clock held low past the timeout
    logic       smp_tick;     // Sample period elapsed

    // Widen a 13-bit signed value by one bit
    function automatic logic signed [13:0] sx(input logic [12:0] v);
        sx = {v[12], v};
    endfunction

    // Hysteresis amount for a select code
    function automatic logic [13:0] hyst(input logic [1:0] sel);
        case (sel)
            2'b00:   hyst = tae_pkg::HYST_0;
            2'b01:   hyst = tae_pkg::HYST_1;
            2'b10:   hyst = tae_pkg::HYST_2;
            default: hyst = tae_pkg::HYST_3;
        endcase
    endfunction

    // All bus pins come from another domain
    tae_sync #(
        .W (5)
    ) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .pin_in  ({addr_select_bit2, addr_select_bit1, addr_select_bit0, sda_i, scl_i}),
        .pin_out (pins_f)
    );

    assign scl_f = pins_f[0];
    assign sda_f = pins_f[1];
    // pull-down default: an open pin settles low at the pad, so no RTL override
    assign sel_f = pins_f[4:2];

    // clock-low watchdog: counter restarts whenever the clock is high
    tae_tick #(
        .CYCLES (TIMEOUT_CYCLES)
    ) u_tmo (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .clr     (scl_f | ~CAP_TMO),
        .done    (tmo_hit)
    );

    // sample pacing, 100 ms keeps well above eight per second
    tae_tick #(
        .CYCLES (SAMPLE_CYCLES)
    ) u_smp (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .clr     (1'b0),
        .done    (smp_tick)
    );

    // Next-state logic for registers, alarm and serial slave
    always_comb begin
        logic              scl_rise;
        logic              scl_fall;
        logic              start_c;
        logic              stop_c;
        logic signed [13:0] t;
        logic signed [13:0] h;
        logic              win_old;
        logic              alarm;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c  = 1'b0;
        stop_c   = 1'b0;
        t        = '0;
        h        = '0;
        win_old  = 1'b0;
        alarm    = 1'b0;

        st_d       = st_q;
        st_d.scl_d = scl_f;
        st_d.sda_d = sda_f;
        scl_rise   = scl_f & ~st_q.scl_d;
        scl_fall   = ~scl_f & st_q.scl_d;
        start_c    = scl_f & st_q.scl_d & st_q.sda_d & ~sda_f;
        stop_c     = scl_f & st_q.scl_d & ~st_q.sda_d & sda_f;

        // ---------------- Register port ----------------
        if (reg_wr) begin
            // Address decode for writes
            if (reg_addr == tae_pkg::REG_CONFIG) begin
                st_d.cfg.int_mode  = reg_wdata[tae_pkg::CFG_INT_MODE];
                st_d.cfg.pol_high  = reg_wdata[tae_pkg::CFG_POL_HIGH];
                st_d.cfg.crit_only = reg_wdata[tae_pkg::CFG_CRIT_ONLY];
                st_d.cfg.win_en    = reg_wdata[tae_pkg::CFG_WIN_EN];
                st_d.cfg.shutdown  = reg_wdata[tae_pkg::CFG_SHUTDOWN];
                st_d.cfg.hyst_sel  = reg_wdata[tae_pkg::CFG_HYST_LO +: 2];
                // clear latch: only the interrupt latch is touched
                if (reg_wdata[tae_pkg::CFG_CLEAR]) begin
                    st_d.int_lat = 1'b0;
                end
                // shutdown entry: release if capable, else freeze
                if (reg_wdata[tae_pkg::CFG_SHUTDOWN] && !st_q.cfg.shutdown && CAP_SD_RELEASE) begin
                    st_d.sd_rel = 1'b1;
                end
            end else if (reg_addr == tae_pkg::REG_UPPER) begin
                st_d.lim.upper = reg_wdata[12:0];
            end else if (reg_addr == tae_pkg::REG_LOWER) begin
                st_d.lim.lower = reg_wdata[12:0];
            end else if (reg_addr == tae_pkg::REG_CRIT) begin
                st_d.lim.crit = reg_wdata[12:0];
            end
        end

        // Read answer, valid the cycle after the strobe only
        st_d.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == tae_pkg::REG_CAPS) begin
                st_d.rdata                       = CAP_OTHER;
                st_d.rdata[tae_pkg::CAP_TMO_SEL] = CAP_TMO;
                st_d.rdata[tae_pkg::CAP_SD_REL]  = CAP_SD_RELEASE;
            end else if (reg_addr == tae_pkg::REG_CONFIG) begin
                st_d.rdata[tae_pkg::CFG_INT_MODE]      = st_q.cfg.int_mode;
                st_d.rdata[tae_pkg::CFG_POL_HIGH]      = st_q.cfg.pol_high;
                st_d.rdata[tae_pkg::CFG_CRIT_ONLY]     = st_q.cfg.crit_only;
                st_d.rdata[tae_pkg::CFG_WIN_EN]        = st_q.cfg.win_en;
                st_d.rdata[tae_pkg::CFG_STATUS]        = ~alarm_oe_n;
                st_d.rdata[tae_pkg::CFG_SHUTDOWN]      = st_q.cfg.shutdown;
                st_d.rdata[tae_pkg::CFG_HYST_LO +: 2]  = st_q.cfg.hyst_sel;
            end else if (reg_addr == tae_pkg::REG_UPPER) begin
                st_d.rdata = {3'b000, st_q.lim.upper};
            end else if (reg_addr == tae_pkg::REG_LOWER) begin
                st_d.rdata = {3'b000, st_q.lim.lower};
            end else if (reg_addr == tae_pkg::REG_CRIT) begin
                st_d.rdata = {3'b000, st_q.lim.crit};
            end else if (reg_addr == tae_pkg::REG_TEMP) begin
                st_d.rdata = {3'b000, st_q.temp};
            end
        end

        // ---------------- Alarm evaluation ----------------
        // sample update: frozen while in shutdown
        if (temp_sample_valid && !st_q.cfg.shutdown) begin
            t         = sx(temp_sample);
            h         = $signed(hyst(st_q.cfg.hyst_sel));
            st_d.temp = temp_sample;
            win_old   = st_q.above_up | st_q.below_lo;
            // hysteresis: each flag sets past the limit, releases past it by the hysteresis amount
            if (t > sx(st_q.lim.upper)) begin
                st_d.above_up = 1'b1;
            end else if (t < sx(st_q.lim.upper) - h) begin
                st_d.above_up = 1'b0;
            end
            if (t < sx(st_q.lim.lower)) begin
                st_d.below_lo = 1'b1;
            end else if (t > sx(st_q.lim.lower) + h) begin
                st_d.below_lo = 1'b0;
            end
            if (t > sx(st_q.lim.crit)) begin
                st_d.above_crit = 1'b1;
            end else if (t < sx(st_q.lim.crit) - h) begin
                st_d.above_crit = 1'b0;
            end
            // crossing in or out: set wins over a same-cycle clear
            if (st_q.cfg.win_en && ((st_d.above_up | st_d.below_lo) != win_old)) begin
                st_d.int_lat = 1'b1;
            end
            // release lasts until this new sample
            st_d.sd_rel = 1'b0;
        end

        // ---------------- Serial slave ----------------
        // clock line is never driven; only data is pulled
        case (st_q.slv)
            tae_pkg::SS_ADDR: begin
                if (scl_rise) begin
                    st_d.sh   = {st_q.sh[6:0], sda_f};
                    st_d.bcnt = st_q.bcnt + 4'h1;
                end else if (scl_fall && st_q.bcnt == 4'h8) begin
                    if (st_q.sh[7:1] == {tae_pkg::SLAVE_HI, sel_f}) begin
                        st_d.sda_low = 1'b1;
                        st_d.rw      = st_q.sh[0];
                        st_d.slv     = tae_pkg::SS_ACK_A;
                        // Frozen word keeps both read bytes from one sample
                        st_d.snap    = {3'b000, st_q.temp};
                        st_d.byte_lo = 1'b0;
                    end else begin
                        st_d.slv = tae_pkg::SS_IDLE;
                    end
                end
            end
            tae_pkg::SS_ACK_A, tae_pkg::SS_WR_ACK: begin
                if (scl_fall) begin
                    st_d.bcnt = 4'h0;
                    if (st_q.slv == tae_pkg::SS_ACK_A && st_q.rw) begin
                        // First read byte, high half
                        st_d.tx      = st_q.snap[15:8];
                        st_d.sda_low = ~st_q.snap[15];
                        st_d.byte_lo = 1'b1;
                        st_d.slv     = tae_pkg::SS_RD;
                    end else begin
                        st_d.sda_low = 1'b0;
                        st_d.slv     = tae_pkg::SS_WR;
                    end
                end
            end
            tae_pkg::SS_RD: begin
                if (scl_rise) begin
                    st_d.bcnt = st_q.bcnt + 4'h1;
                end else if (scl_fall) begin
                    if (st_q.bcnt == 4'h8) begin
                        st_d.sda_low = 1'b0;
                        st_d.slv     = tae_pkg::SS_RD_ACK;
                    end else begin
                        st_d.tx      = {st_q.tx[6:0], 1'b0};
                        st_d.sda_low = ~st_q.tx[6];
                    end
                end
            end
            tae_pkg::SS_RD_ACK: begin
                if (scl_rise) begin
                    st_d.m_ack = ~sda_f;
                end else if (scl_fall) begin
                    st_d.bcnt = 4'h0;
                    if (st_q.m_ack) begin
                        // Bytes alternate high, low, high...
                        st_d.tx      = st_q.byte_lo ? st_q.snap[7:0] : st_q.snap[15:8];
                        st_d.sda_low = st_q.byte_lo ? ~st_q.snap[7] : ~st_q.snap[15];
                        st_d.byte_lo = ~st_q.byte_lo;
                        st_d.slv     = tae_pkg::SS_RD;
                    end else begin
                        st_d.slv = tae_pkg::SS_IDLE;
                    end
                end
            end
            tae_pkg::SS_WR: begin
                // Written bytes are acknowledged and dropped here
                if (scl_rise) begin
                    st_d.bcnt = st_q.bcnt + 4'h1;
                end else if (scl_fall && st_q.bcnt == 4'h8) begin
                    st_d.sda_low = 1'b1;
                    st_d.slv     = tae_pkg::SS_WR_ACK;
                end
            end
            default: begin
                st_d.sda_low = 1'b0;
            end
        endcase

        // Start and stop override any state
        if (start_c) begin
            st_d.slv     = tae_pkg::SS_ADDR;
            st_d.bcnt    = 4'h0;
            st_d.sh      = 8'h00;
            st_d.sda_low = 1'b0;
        end else if (stop_c) begin
            st_d.slv     = tae_pkg::SS_IDLE;
            st_d.sda_low = 1'b0;
        end
        // abandon on timeout, ready for a fresh start at once
        if (tmo_hit) begin
            st_d.slv     = tae_pkg::SS_IDLE;
            st_d.sda_low = 1'b0;
        end
        alarm = 1'b0;
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q     <= '0;
            st_q.cfg <= tae_pkg::tae_cfg_s'(7'h00);
            st_q.lim <= {tae_pkg::LIMIT_RST, tae_pkg::LIMIT_RST, tae_pkg::LIMIT_RST};
            st_q.slv <= tae_pkg::SS_IDLE;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // Alarm output composition
    logic alarm_act;
    always_comb begin
        // critical part is never latched, so clear cannot touch it
        if (st_q.cfg.crit_only) begin
            alarm_act = st_q.above_crit;
        end else if (st_q.cfg.int_mode) begin
            alarm_act = st_q.int_lat | st_q.above_crit;
        end else begin
            alarm_act = (st_q.cfg.win_en & (st_q.above_up | st_q.below_lo)) | st_q.above_crit;
        end
        if (st_q.sd_rel) begin
            alarm_act = 1'b0;
        end
    end

    // open drain: asserted level driven, else released
    assign alarm_o    = st_q.cfg.pol_high;
    assign alarm_oe_n = ~alarm_act;

    assign sda_o      = 1'b0;
    assign sda_oe_n   = ~st_q.sda_low;
    assign reg_rdata  = st_q.rdata;
    assign sample_req = smp_tick;
endmodule
`default_nettype wire

// *** tae_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module tae_top_bench;
    logic        sys_clk = 0;
    logic        nrst = 0;
    logic        reg_wr = 0;
    logic        reg_rd = 0;
    logic        tv = 0;
    logic        go = 0;
    logic [3:0]  ra = 4'h0;
    logic [15:0] wd = 16'h0000;
    logic [12:0] ts = 13'h0000;
    logic [6:0]  hadr = 7'h00;
    logic [2:0]  sel = 3'h5;
    logic [15:0] rdata;
    logic        sreq, sda_o, sda_oe_n, al_o, al_oe_n, scl, hsda, acked, busy;
    wire logic   sda_w = hsda & sda_oe_n;  // Pulled-up data line
    int          miscompares = 0;
    int          n_tests = 0;
    int          cyc = 0;
    always #12.5 sys_clk = ~sys_clk;
    tae_top #(.TIMEOUT_CYCLES(200), .SAMPLE_CYCLES(100)) tae_top_i (.sys_clk, .nrst, .clk_en(1'b1), .reg_addr(ra),
        .reg_wdata(wd), .reg_wr, .reg_rd, .reg_rdata(rdata), .sample_req(sreq), .temp_sample(ts),
        .temp_sample_valid(tv), .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_n, .addr_select_bit0(sel[0]),
        .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]), .alarm_o(al_o), .alarm_oe_n(al_oe_n));
    tae_host tae_host_i (.go, .addr(hadr), .sda_in(sda_w), .scl, .sda(hsda), .acked, .busy);
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge sys_clk); ra <= a; wd <= d; reg_wr <= 1'b1;
        @(posedge sys_clk); reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge sys_clk); ra <= a; reg_rd <= 1'b1;
        @(posedge sys_clk); reg_rd <= 1'b0;
        #1 chk("read data", rdata, e);
    endtask
    // Sample, then look at the released/driven state once it has landed
    task automatic smp(logic [12:0] t, logic e);
        @(posedge sys_clk); ts <= t; tv <= 1'b1;
        @(posedge sys_clk); tv <= 1'b0;
        @(posedge sys_clk); #1 chk("alarm_oe_n", al_oe_n, e);
    endtask
    task automatic bus(logic [6:0] a, logic e);
        @(posedge sys_clk); hadr <= a; go <= 1'b1;
        @(posedge sys_clk); go <= 1'b0;
        repeat (1000) if (busy) @(posedge sys_clk);
        if (busy) miscompares++;
        chk("acked", acked, e);
    endtask
    always @(posedge sys_clk) if (++cyc == 20000) begin miscompares++; close_out(); end
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(4'h0, 16'h004F); rd(4'h1, 16'h0000); rd(4'h4, 16'h0000); wr(4'h0, 16'h0000); rd(4'h0, 16'h004F);
        wr(4'hF, 16'hFFFF); rd(4'hF, 16'h0000); wr(4'h2, 16'hFFFF); rd(4'h2, 16'h1FFF);
        $display("registers done");
        wr(4'h4, 16'h0FFF); wr(4'h2, 16'h0100); wr(4'h3, 16'h0000); wr(4'h1, 16'h000A);
        smp(13'h0140, 1'b0); chk("alarm_o", al_o, 1'b1);
        rd(4'h2, 16'h0100); chk("alarm_oe_n", al_oe_n, 1'b0);
        wr(4'h1, 16'h002A); @(posedge sys_clk); #1 chk("alarm_oe_n", al_oe_n, 1'b0);
        smp(13'h00F0, 1'b1);
        wr(4'h1, 16'h020A); smp(13'h0110, 1'b0); smp(13'h00F0, 1'b0);
        smp(13'h00E0, 1'b1);
        $display("comparator done");
        wr(4'h1, 16'h0009); smp(13'h0140, 1'b0); chk("alarm_o", al_o, 1'b0);
        wr(4'h1, 16'h0029); @(posedge sys_clk); #1 chk("alarm_oe_n", al_oe_n, 1'b1);
        smp(13'h0140, 1'b1);
        smp(13'h00F0, 1'b0);
        wr(4'h1, 16'h0029); wr(4'h4, 16'h0200); wr(4'h1, 16'h0004);
        smp(13'h0150, 1'b1); smp(13'h0210, 1'b0);
        wr(4'h1, 16'h0024); smp(13'h0210, 1'b0);
        smp(13'h0150, 1'b1);
        wr(4'h1, 16'h0104); smp(13'h0210, 1'b1);
        rd(4'h5, 16'h0150);
        $display("interrupt and critical done");
        bus(7'h1B, 1'b0);
        bus(7'h1D, 1'b1);
        bus(7'h1D, 1'b1);
        sel <= 3'h0;
        bus(7'h18, 1'b1);
        $display("serial done");
        close_out();
    end
endmodule
`default_nettype wire
